// [rtl/lao_top.sv]
// lens actuator option logic: backlash return move and actuator drive
// Functional notes
// - type 0 none, 1 bender, 2 stepper
// - mode bits 7:6 zero: direct return move
// - return move opposes scan direction
// - target is best position minus backlash
// - negative target clamps to zero
// - type 0 ignores all option bits
// - bender bit 0: 2 or 3 byte command
// - bender bit 1: send 255 minus position
// - bender bit 2: wake at lower/upper limit
// - stepper bit 1: logical target or step count
// - stepper bit 2: periodic output forcing
// - power up always, bit 3 powers down
// - stepper bit 4: rehome on standby entry
// - stepper bit 5: rehome on standby exit
// - stepper bits 7:6 slow waveform starts
`timescale 1ns/1ps
`default_nettype none
module lao_top #(
  parameter int STEP_CYCLES = lao_pkg::STEP_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire lao_pkg::lao_reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [1:0] actuator_type_in,
  input wire logic [7:0] focus_search_config_in,
  input wire logic scan_done_in,
  input wire logic scan_down_in,
  input wire logic [7:0] best_pos_in,
  input wire logic move_req_in,
  input wire logic [7:0] requested_position_in,
  input wire logic standby_enter_in,
  input wire logic standby_exit_in,
  input wire logic [7:0] lower_travel_limit_in,
  input wire logic [7:0] upper_travel_limit_in,
  output lao_pkg::lao_bender_cmd_t bender_cmd_out,
  output lao_pkg::lao_motor_t motor_out,
  output logic [7:0] repos_target_out,
  output logic repos_dir_down_out,
  output logic [7:0] cur_pos_out,
  output logic busy_out
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_POWER = 2'b01,
    ST_STEP = 2'b11,
    ST_DONE = 2'b10
  } lao_st_t;

  localparam int PW = $clog2(lao_pkg::POWER_CYCLES + 1);
  localparam int FW = $clog2(lao_pkg::FORCE_CYCLES + 1);
  localparam logic [PW-1:0] PWR_LAST = PW'(lao_pkg::POWER_CYCLES - 1);
  localparam logic [FW-1:0] FRC_LAST = FW'(lao_pkg::FORCE_CYCLES - 1);

  logic [7:0] backlash_q;
  logic [7:0] options_q;
  logic [7:0] opt;
  lao_pkg::lao_act_t act;
  logic is_bender;
  logic is_stepper;
  logic [7:0] bl_target;
  logic bl_down;
  logic repos_go;
  logic req_go;
  logic [7:0] req_pos;
  logic req_steps;
  logic req_down;
  lao_st_t st_q;
  logic [7:0] steps_left_q;
  logic [7:0] steps_done_q;
  logic dir_down_q;
  logic [PW-1:0] pwr_cnt_q;
  logic [FW-1:0] frc_cnt_q;
  logic tick;
  logic [1:0] stretch;
  logic [7:0] phys_pos;
  logic power_q;
  logic [3:0] coil_q;

  // register file at the documented offsets
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      backlash_q <= lao_pkg::RST_BACKLASH;
      options_q <= lao_pkg::RST_OPTIONS;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == lao_pkg::OFS_BACKLASH) begin
        backlash_q <= reg_req_in.data;
      end
      if (reg_req_in.addr == lao_pkg::OFS_OPTIONS) begin
        options_q <= reg_req_in.data;
      end
    end
  end

  // read data one cycle after the strobe, unmapped offsets read zero
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_req_in.rd) begin
      if (reg_req_in.addr == lao_pkg::OFS_BACKLASH) begin
        reg_rdata_out <= backlash_q;
      end else if (reg_req_in.addr == lao_pkg::OFS_OPTIONS) begin
        reg_rdata_out <= options_q;
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  // code 3 is treated like no actuator
  always_comb begin
    act = lao_pkg::LAO_ACT_NONE;
    unique case (actuator_type_in)
      2'h1: act = lao_pkg::LAO_ACT_BENDER;
      2'h2: act = lao_pkg::LAO_ACT_STEPPER;
      default: act = lao_pkg::LAO_ACT_NONE;
    endcase
  end
  assign is_bender = (act == lao_pkg::LAO_ACT_BENDER);
  assign is_stepper = (act == lao_pkg::LAO_ACT_STEPPER);
  // the stored value stays readable; only its effect is masked
  assign opt = (act == lao_pkg::LAO_ACT_NONE) ? 8'h00 : options_q;

  lao_backlash u_backlash (
    .best_pos_in(best_pos_in),
    .step_in(backlash_q),
    .scan_down_in(scan_down_in),
    .target_out(bl_target),
    .dir_down_out(bl_down)
  );

  // the direct return is used only in that search mode
  assign repos_go = scan_done_in &&
    (focus_search_config_in[lao_pkg::MODE_REPOS_LSB +: 2] == 2'h0);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      repos_target_out <= 8'h00;
      repos_dir_down_out <= 1'b0;
    end else if (repos_go) begin
      repos_target_out <= bl_target;
      repos_dir_down_out <= bl_down;
    end
  end

  // request arbitration: return move, then host move, then standby
  always_comb begin
    req_go = 1'b0;
    req_pos = requested_position_in;
    req_steps = 1'b0;
    req_down = opt[lao_pkg::OPT_DIR_DOWN];
    if (repos_go) begin
      // the return target is always a logical position
      req_go = 1'b1;
      req_pos = bl_target;
    end else if (move_req_in) begin
      req_go = 1'b1;
      req_steps = is_stepper && opt[lao_pkg::OPT_STEP_MODE];
    end else if (is_bender && standby_exit_in) begin
      req_go = 1'b1;
      req_pos = opt[lao_pkg::OPT_WAKE_UPPER] ? upper_travel_limit_in
                                             : lower_travel_limit_in;
    end else if (is_stepper && standby_enter_in &&
                 opt[lao_pkg::OPT_REHOME_ENTER]) begin
      req_go = 1'b1;
      req_pos = lower_travel_limit_in;
    end else if (is_stepper && standby_exit_in &&
                 opt[lao_pkg::OPT_REHOME_EXIT]) begin
      req_go = 1'b1;
      req_pos = lower_travel_limit_in;
    end
  end

  // bender command, one cycle pulse per request
  assign phys_pos = opt[lao_pkg::OPT_INVERT] ? (lao_pkg::POS_TOP - req_pos)
                                             : req_pos;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      bender_cmd_out <= '0;
    end else if (is_bender && req_go) begin
      bender_cmd_out.valid <= 1'b1;
      bender_cmd_out.len3 <= opt[lao_pkg::OPT_LEN3];
      bender_cmd_out.pos <= phys_pos;
    end else begin
      bender_cmd_out.valid <= 1'b0;
    end
  end

  // slow start applies only to the first steps of each move
  assign stretch = (steps_done_q < lao_pkg::SLOW_STEPS)
                   ? opt[lao_pkg::OPT_SLOW_LSB +: 2] : 2'h0;

  lao_step_timer #(
    .PERIOD(STEP_CYCLES)
  ) u_step_timer (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .run_in(st_q == ST_STEP),
    .stretch_in(stretch),
    .tick_out(tick)
  );

  // stepper move sequencer
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_q <= ST_IDLE;
      steps_left_q <= 8'h00;
      steps_done_q <= 8'h00;
      dir_down_q <= 1'b0;
      pwr_cnt_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (is_stepper && req_go) begin
            steps_done_q <= 8'h00;
            pwr_cnt_q <= '0;
            st_q <= ST_POWER;
            if (req_steps) begin
              steps_left_q <= req_pos;
              dir_down_q <= req_down;
            end else if (req_pos < cur_pos_out) begin
              steps_left_q <= cur_pos_out - req_pos;
              dir_down_q <= 1'b1;
            end else begin
              steps_left_q <= req_pos - cur_pos_out;
              dir_down_q <= 1'b0;
            end
          end
        end
        ST_POWER: begin
          // coils get time to settle after power is applied
          if (pwr_cnt_q == PWR_LAST) begin
            st_q <= ST_STEP;
          end else begin
            pwr_cnt_q <= pwr_cnt_q + PW'(1);
          end
        end
        ST_STEP: begin
          if (steps_left_q == 8'h00) begin
            st_q <= ST_DONE;
          end else if (tick) begin
            steps_left_q <= steps_left_q - 8'h01;
            steps_done_q <= steps_done_q + 8'h01;
          end
        end
        ST_DONE: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // logical position; step counts stop at the ends of the range
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cur_pos_out <= 8'h00;
    end else if (is_bender && req_go) begin
      cur_pos_out <= req_pos;
    end else if (st_q == ST_STEP && tick && steps_left_q != 8'h00) begin
      if (dir_down_q && cur_pos_out != lao_pkg::POS_ZERO) begin
        cur_pos_out <= cur_pos_out - 8'h01;
      end else if (!dir_down_q && cur_pos_out != lao_pkg::POS_TOP) begin
        cur_pos_out <= cur_pos_out + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (st_q != ST_IDLE) || (is_stepper && req_go);
    end
  end

  // refresh period for forced coil states
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || frc_cnt_q == FRC_LAST) begin
      frc_cnt_q <= '0;
    end else begin
      frc_cnt_q <= frc_cnt_q + FW'(1);
    end
  end

  // motor drive: power and coils
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      power_q <= 1'b0;
    end else if (!is_stepper) begin
      power_q <= 1'b0;
    end else if (st_q == ST_POWER) begin
      power_q <= 1'b1;
    end else if (st_q == ST_DONE && opt[lao_pkg::OPT_PWR_DOWN]) begin
      power_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      coil_q <= 4'h0;
    end else if (is_stepper && st_q == ST_STEP && tick) begin
      // coils follow the position about to be reached
      if (dir_down_q) begin
        coil_q <= lao_pkg::lao_coils(cur_pos_out[1:0] - 2'h1);
      end else begin
        coil_q <= lao_pkg::lao_coils(cur_pos_out[1:0] + 2'h1);
      end
    end else if (is_stepper && opt[lao_pkg::OPT_FORCE] &&
                 frc_cnt_q == FRC_LAST) begin
      // rewrites the coils from the position, healing any upset
      coil_q <= lao_pkg::lao_coils(cur_pos_out[1:0]);
    end
  end

  // one driver for the whole struct, both fields straight from flops
  assign motor_out = {power_q, coil_q};
endmodule
`default_nettype wire

// [rtl/lao_pkg.sv]
// shared constants and types for the lens actuator option logic
package lao_pkg;
  localparam logic [7:0] OFS_BACKLASH = 8'h09;
  localparam logic [7:0] OFS_OPTIONS = 8'h0a;
  localparam logic [7:0] RST_BACKLASH = 8'h00;
  localparam logic [7:0] RST_OPTIONS = 8'h00;
  localparam logic [7:0] POS_TOP = 8'hff;
  localparam logic [7:0] POS_ZERO = 8'h00;

  typedef enum logic [1:0] {
    LAO_ACT_NONE = 2'h0,
    LAO_ACT_BENDER = 2'h1,
    LAO_ACT_STEPPER = 2'h2
  } lao_act_t;

  // focus_search_config field that picks the repositioning method
  localparam int MODE_REPOS_LSB = 6;
  // option switch positions, bender
  localparam int OPT_LEN3 = 0;
  localparam int OPT_INVERT = 1;
  localparam int OPT_WAKE_UPPER = 2;
  // option switch positions, stepper
  localparam int OPT_DIR_DOWN = 0;
  localparam int OPT_STEP_MODE = 1;
  localparam int OPT_FORCE = 2;
  localparam int OPT_PWR_DOWN = 3;
  localparam int OPT_REHOME_ENTER = 4;
  localparam int OPT_REHOME_EXIT = 5;
  localparam int OPT_SLOW_LSB = 6;

  localparam int CLK_PERIOD_NS = 5;
  localparam int STEP_TIME_NS = 1000000;
  localparam int POWER_UP_NS = 10000;
  localparam int FORCE_TIME_NS = 20000;
  // least times, rounded up to whole cycles
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int POWER_CYCLES = (POWER_UP_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int FORCE_CYCLES = (FORCE_TIME_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam logic [7:0] SLOW_STEPS = 8'h04;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } lao_reg_req_t;

  typedef struct packed {
    logic valid;
    logic len3;
    logic [7:0] pos;
  } lao_bender_cmd_t;

  typedef struct packed {
    logic power;
    logic [3:0] coil;
  } lao_motor_t;

  function automatic logic [3:0] lao_coils(input logic [1:0] ph);
    logic [3:0] c;
    c = 4'h3;
    case (ph)
      2'h0: c = 4'h3;
      2'h1: c = 4'h6;
      2'h2: c = 4'hc;
      default: c = 4'h9;
    endcase
    return c;
  endfunction
endpackage

// [rtl/lao_backlash.sv]
// saturating backlash subtraction for the return move after a scan
`timescale 1ns/1ps
`default_nettype none
module lao_backlash (
  input wire logic [7:0] best_pos_in,
  input wire logic [7:0] step_in,
  input wire logic scan_down_in,
  output logic [7:0] target_out,
  output logic dir_down_out
);
  logic [8:0] diff;
  // unsigned 8-bit, one extra bit only to spot the borrow
  assign diff = {1'b0, best_pos_in} - {1'b0, step_in};
  assign target_out = diff[8] ? lao_pkg::POS_ZERO : diff[7:0];
  // return travel runs against the scan
  assign dir_down_out = ~scan_down_in;
endmodule
`default_nettype wire

// [rtl/lao_step_timer.sv]
// step rate divider with a stretch factor for slowed waveform starts
`timescale 1ns/1ps
`default_nettype none
module lao_step_timer #(
  parameter int PERIOD = 200000
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic run_in,
  input wire logic [1:0] stretch_in,
  output logic tick_out
);
  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  logic [CW-1:0] cnt_q;
  logic [1:0] rep_q;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in || !run_in) begin
      cnt_q <= '0;
      rep_q <= 2'h0;
      tick_out <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
      // each base period repeats stretch times before the tick
      if (rep_q >= stretch_in) begin
        rep_q <= 2'h0;
        tick_out <= 1'b1;
      end else begin
        rep_q <= rep_q + 2'h1;
        tick_out <= 1'b0;
      end
    end else begin
      cnt_q <= cnt_q + CW'(1);
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [test/lao_top_sva.sv]
// port assertions for the lens actuator option logic
`timescale 1ns/1ps
`default_nettype none
module lao_top_sva #(
  parameter int STEP_CYCLES = 8
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire lao_pkg::lao_reg_req_t reg_req_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [1:0] actuator_type_in,
  input wire logic [7:0] focus_search_config_in,
  input wire logic scan_done_in,
  input wire logic scan_down_in,
  input wire logic [7:0] best_pos_in,
  input wire logic move_req_in,
  input wire logic [7:0] requested_position_in,
  input wire logic standby_enter_in,
  input wire logic standby_exit_in,
  input wire logic [7:0] lower_travel_limit_in,
  input wire logic [7:0] upper_travel_limit_in,
  input wire lao_pkg::lao_bender_cmd_t bender_cmd_out,
  input wire lao_pkg::lao_motor_t motor_out,
  input wire logic [7:0] repos_target_out,
  input wire logic repos_dir_down_out,
  input wire logic [7:0] cur_pos_out,
  input wire logic busy_out
);
  logic [7:0] bl_q, opt_q, rd_exp, sat_d;
  logic ret_go, mv_go;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // shadow of both registers, kept from the write strobes alone
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      bl_q <= 8'h00;
      opt_q <= 8'h00;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == lao_pkg::OFS_BACKLASH) bl_q <= reg_req_in.data;
      if (reg_req_in.addr == lao_pkg::OFS_OPTIONS) opt_q <= reg_req_in.data;
    end
  end
  always_comb begin
    rd_exp = 8'h00;
    if (reg_req_in.addr == lao_pkg::OFS_BACKLASH) rd_exp = bl_q;
    if (reg_req_in.addr == lao_pkg::OFS_OPTIONS) rd_exp = opt_q;
  end
  assign sat_d = (best_pos_in > bl_q) ? best_pos_in - bl_q : 8'h00;
  assign ret_go = scan_done_in && focus_search_config_in[7:6] == 2'h0;
  assign mv_go = move_req_in && !ret_go && actuator_type_in == 2'h1;
  sequence s_start;
    !busy_out ##1 busy_out;
  endsequence
  sequence s_finish;
    busy_out ##1 (!busy_out && opt_q[3]);
  endsequence
  chk_read_data: assert property (
    reg_req_in.rd |=> reg_rdata_out == $past(rd_exp))
    else $error("register read data wrong");
  chk_repos_target: assert property (
    ret_go |=> repos_target_out == $past(sat_d))
    else $error("return target wrong");
  chk_repos_dir: assert property (
    ret_go |=> repos_dir_down_out == !$past(scan_down_in))
    else $error("return direction wrong");
  chk_cmd_source: assert property (
    bender_cmd_out.valid |-> $past(actuator_type_in) == 2'h1)
    else $error("command from wrong actuator type");
  chk_cmd_len: assert property (
    bender_cmd_out.valid |-> bender_cmd_out.len3 == $past(opt_q[0]))
    else $error("command length wrong");
  chk_cmd_pos: assert property (mv_go |=> bender_cmd_out.valid &&
    bender_cmd_out.pos == ($past(opt_q[1]) ?
    8'hff - $past(requested_position_in) : $past(requested_position_in)))
    else $error("command position wrong");
  chk_power_up: assert property (s_start |=> motor_out.power)
    else $error("motor not powered before moving");
  chk_power_down: assert property (s_finish |-> !motor_out.power)
    else $error("motor not powered down");
endmodule
bind lao_top lao_top_sva #(.STEP_CYCLES(STEP_CYCLES)) u_lao_top_sva (
  .ref_clk_in, .reset_in, .reg_req_in, .reg_rdata_out, .actuator_type_in,
  .focus_search_config_in, .scan_done_in, .scan_down_in, .best_pos_in,
  .move_req_in, .requested_position_in, .standby_enter_in,
  .standby_exit_in, .lower_travel_limit_in, .upper_travel_limit_in,
  .bender_cmd_out, .motor_out, .repos_target_out, .repos_dir_down_out,
  .cur_pos_out, .busy_out);
`default_nettype wire

// [test/lao_far_side.sv]
// far side model: counts driver bytes and stepper coil steps
`timescale 1ns/1ps
`default_nettype none
module lao_far_side (
  input wire logic ref_clk_in,
  input wire lao_pkg::lao_bender_cmd_t cmd_in,
  input wire lao_pkg::lao_motor_t motor_in,
  output logic [7:0] bytes_out,
  output logic [7:0] steps_out,
  output logic [7:0] unpowered_out
);
  logic [3:0] coil_q;
  initial begin
    bytes_out = 8'h00;
    steps_out = 8'h00;
    unpowered_out = 8'h00;
    coil_q = 4'h0;
  end
  // falling back to the all-off reset pattern is no step; leaving it is
  always @(posedge ref_clk_in) begin
    if (cmd_in.valid) begin
      bytes_out <= bytes_out + (cmd_in.len3 ? 8'h03 : 8'h02);
    end
    if (motor_in.coil != coil_q && motor_in.coil != 4'h0) begin
      steps_out <= steps_out + 8'h01;
      if (!motor_in.power) unpowered_out <= unpowered_out + 8'h01;
    end
    coil_q <= motor_in.coil;
  end
endmodule
`default_nettype wire

// [test/lao_top_bench.sv]
// self-checking bench for the lens actuator option logic
`timescale 1ns/1ps
`default_nettype none
module lao_top_bench;
  logic ref_clk_in, reset_in, scan_done_in, scan_down_in, move_req_in;
  logic standby_enter_in, standby_exit_in, repos_dir_down_out, busy_out;
  logic [1:0] actuator_type_in;
  logic [7:0] focus_search_config_in, best_pos_in, requested_position_in;
  logic [7:0] lower_travel_limit_in, upper_travel_limit_in, reg_rdata_out;
  logic [7:0] repos_target_out, cur_pos_out, rd, nbytes, nsteps, nbad;
  lao_pkg::lao_reg_req_t reg_req_in;
  lao_pkg::lao_bender_cmd_t bender_cmd_out;
  lao_pkg::lao_motor_t motor_out;
  int errors, comparisons, waited;
  lao_top #(.STEP_CYCLES(8)) u_lao_top (.ref_clk_in, .reset_in, .reg_req_in,
    .reg_rdata_out, .actuator_type_in, .focus_search_config_in,
    .scan_done_in, .scan_down_in, .best_pos_in, .move_req_in,
    .requested_position_in, .standby_enter_in, .standby_exit_in,
    .lower_travel_limit_in, .upper_travel_limit_in, .bender_cmd_out,
    .motor_out, .repos_target_out, .repos_dir_down_out, .cur_pos_out,
    .busy_out);
  lao_far_side u_lao_far_side (.ref_clk_in(ref_clk_in),
    .cmd_in(bender_cmd_out), .motor_in(motor_out), .bytes_out(nbytes),
    .steps_out(nsteps), .unpowered_out(nbad));
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc();
    reg_req_in = {1'b1, 1'b0, a, d};
    cyc();
    reg_req_in = 18'h0;
  endtask
  task automatic rdr(input logic [7:0] a);
    cyc();
    reg_req_in = {1'b0, 1'b1, a, 8'h00};
    cyc();
    reg_req_in = 18'h0;
    rd = reg_rdata_out;
  endtask
  // one-cycle pulse: 0 scan done, 1 move, 2 standby enter, 3 standby exit
  task automatic pls(input int k);
    cyc();
    {scan_done_in, move_req_in, standby_enter_in, standby_exit_in} = 4'h8 >> k;
    cyc();
    {scan_done_in, move_req_in, standby_enter_in, standby_exit_in} = 4'h0;
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (busy_out === 1'b1 && n < 6000) begin
      cyc();
      n++;
    end
    waited = n;
    if (n == 6000) chk("idle", 8'h01, 8'h00);
  endtask
  task automatic t_regs();
    rdr(8'h09);
    chk("backlash rst", rd, 8'h00);
    rdr(8'h0a);
    chk("options rst", rd, 8'h00);
    wr(8'h0a, 8'ha5);
    rdr(8'h0a);
    chk("options", rd, 8'ha5);
    wr(8'h20, 8'hff);
    rdr(8'h20);
    chk("unmapped", rd, 8'h00);
  endtask
  task automatic ret(input logic [7:0] b, input logic dn, input logic [7:0] e);
    best_pos_in = b;
    scan_down_in = dn;
    pls(0);
    chk("target", repos_target_out, e);
    chk("dir", {7'h0, repos_dir_down_out}, {7'h0, ~dn});
    chk("ret cmd", bender_cmd_out.pos, e);
  endtask
  task automatic t_return();
    actuator_type_in = 2'h1;
    wr(8'h0a, 8'h00);
    wr(8'h09, 8'h05);
    ret(8'h03, 1'b0, 8'h00);
    ret(8'h14, 1'b0, 8'h0f);
    wr(8'h09, 8'h00);
    ret(8'h1e, 1'b1, 8'h1e);
    focus_search_config_in = 8'h40;
    best_pos_in = 8'h50;
    pls(0);
    chk("no return", {7'h0, bender_cmd_out.valid}, 8'h00);
    chk("kept target", repos_target_out, 8'h1e);
    focus_search_config_in = 8'h00;
  endtask
  task automatic t_bender();
    logic [7:0] p, b0;
    b0 = nbytes;
    for (int o = 0; o < 8; o++) begin
      wr(8'h0a, o[7:0]);
      requested_position_in = 8'h10;
      pls(1);
      chk("valid", {7'h0, bender_cmd_out.valid}, 8'h01);
      chk("len3", {7'h0, bender_cmd_out.len3}, {7'h0, o[0]});
      chk("pos", bender_cmd_out.pos, o[1] ? 8'hef : 8'h10);
      pls(3);
      p = o[2] ? 8'he0 : 8'h11;
      chk("wake", bender_cmd_out.pos, o[1] ? 8'hff - p : p);
      pls(2);
      chk("enter", {7'h0, bender_cmd_out.valid}, 8'h00);
    end
    chk("bytes", nbytes - b0, 8'h28);
  endtask
  task automatic t_none();
    for (int t = 0; t < 4; t += 3) begin
      actuator_type_in = t[1:0];
      wr(8'h0a, 8'hff);
      pls(1);
      chk("none cmd", {7'h0, bender_cmd_out.valid}, 8'h00);
      chk("none busy", {7'h0, busy_out}, 8'h00);
    end
  endtask
  task automatic st(input logic [7:0] o, input logic [7:0] a,
                    input logic [7:0] e, input logic pw, input logic [7:0] n);
    logic [7:0] s0;
    wr(8'h0a, o);
    s0 = nsteps;
    requested_position_in = a;
    pls(1);
    chk("busy", {7'h0, busy_out}, 8'h01);
    idle();
    chk("cur", cur_pos_out, e);
    chk("power", {7'h0, motor_out.power}, {7'h0, pw});
    chk("steps", nsteps - s0, n);
  endtask
  task automatic t_step();
    reset_in = 1'b1;
    cyc(2);
    reset_in = 1'b0;
    actuator_type_in = 2'h2;
    st(8'h48, 8'h02, 8'h02, 1'b0, 8'h02);
    // settle, two steps of twice the base period, then done and idle
    chk("slow time", 8'(waited - lao_pkg::POWER_CYCLES), 8'h24);
    st(8'h0b, 8'h01, 8'h01, 1'b0, 8'h01);
    st(8'h04, 8'h03, 8'h03, 1'b1, 8'h02);
    chk("coil", {4'h0, motor_out.coil}, 8'h09);
    wr(8'h0a, 8'h20);
    pls(2);
    chk("no rehome", {7'h0, busy_out}, 8'h00);
    pls(3);
    chk("rehome", {7'h0, busy_out}, 8'h01);
    idle();
    chk("home", cur_pos_out, 8'h11);
    wr(8'h0a, 8'h10);
    pls(3);
    chk("exit idle", {7'h0, busy_out}, 8'h00);
    lower_travel_limit_in = 8'h0f;
    pls(2);
    chk("rehome enter", {7'h0, busy_out}, 8'h01);
    idle();
    chk("enter home", cur_pos_out, 8'h0f);
    chk("unpowered", nbad, 8'h00);
    // reset leaves the coils off; only forcing brings back the pattern
    reset_in = 1'b1;
    cyc(2);
    reset_in = 1'b0;
    wr(8'h0a, 8'h04);
    chk("unforced", {4'h0, motor_out.coil}, 8'h00);
    cyc(lao_pkg::FORCE_CYCLES);
    chk("forced", {4'h0, motor_out.coil}, 8'h03);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // about 15000 cycles needed; generous margin before giving up
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    errors++;
    wrap_up();
  end
  initial begin
    reset_in = 1'b1;
    reg_req_in = 18'h0;
    {scan_done_in, move_req_in, standby_enter_in, standby_exit_in} = 4'h0;
    scan_down_in = 1'b0;
    actuator_type_in = 2'h0;
    focus_search_config_in = 8'h00;
    best_pos_in = 8'h00;
    requested_position_in = 8'h00;
    lower_travel_limit_in = 8'h11;
    upper_travel_limit_in = 8'he0;
    cyc(12);
    reset_in = 1'b0;
    t_regs();
    t_return();
    t_bender();
    t_none();
    t_step();
    wrap_up();
  end
endmodule
`default_nettype wire
